// File: src/cps_select.v
/*
 Control pin setting select: in control role three pins index one of eight
 stored settings, in serial role pin a alone picks setting 0 or 1; the
 settings steer three PLLs and the primary output. Registers on a
 classic Wishbone slave with single-cycle ack.
 Assumes pins are synchronous to core_clk; the serial engine and the
 nonvolatile store sit outside and see the serial enable output.
*/
`timescale 1ns/100ps
`include "cps_map.vh"

module cps_select
#(
   parameter NUM_PLL = 3,
   parameter NUM_SET = 8
)
(
   input wire core_clk,
   input wire rst_n,
   input wire ctrl_pin_a,
   input wire ctrl_pin_b_dual,
   input wire ctrl_pin_c_dual,
   input wire output_supply_grounded,
   input wire [31:0] wb_adr_i,
   input wire [31:0] wb_dat_i,
   input wire [3:0] wb_sel_i,
   input wire wb_we_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   output reg serial_enable,
   output reg [2:0] setting_index,
   output reg [1:0] primary_output,
   output reg [1:0] pll_a_output_pair,
   output reg [1:0] pll_b_output_pair,
   output reg [1:0] pll_c_output_pair,
   output reg [NUM_PLL-1:0] pll_freq_select,
   output reg [3*NUM_PLL-1:0] pll_spread_code,
   output reg [NUM_PLL-1:0] pll_spread_down
);

   // ***********************************************
   // Configuration storage
   // ***********************************************
   reg role_volatile;
   reg role_committed;
   reg [3:0] gen_cfg;
   reg [4:0] pll_cfg [0:NUM_PLL-1];
   reg [`CPS_ENT_W-1:0] set_tab [0:NUM_SET-1];
   reg commit_pend;

   wire [`CPS_ADDR_W-1:0] adr;
   wire wr_req;
   wire rd_req;
   wire [1:0] next_gen_st;
   wire serial_role;
   wire [2:0] idx;
   wire [`CPS_ENT_W-1:0] ent;
   wire [NUM_PLL-1:0] dec_freq;
   wire [3*NUM_PLL-1:0] dec_spread;
   wire [NUM_PLL-1:0] dec_down;
   wire [2*NUM_PLL-1:0] dec_state;
   reg [31:0] rd_data;
   integer i;
   integer j;
   integer k;
   wire hit_pincfg;
   wire hit_commit;
   wire hit_status;
   wire hit_gencfg;
   reg [NUM_PLL-1:0] hit_pll;
   reg [NUM_SET-1:0] hit_tab;

   assign adr = wb_adr_i[`CPS_ADDR_W-1:0];
   assign wr_req = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
   assign rd_req = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;

   // ***********************************************
   // Address decode
   // ***********************************************

   // One hit per register word, upper address bits ignored
   assign hit_pincfg = (adr == `CPS_OFF_PINCFG);
   assign hit_commit = (adr == `CPS_OFF_COMMIT);
   assign hit_status = (adr == `CPS_OFF_STATUS);
   assign hit_gencfg = (adr == `CPS_OFF_GENCFG);

   // Hits on per-PLL words and setting table words
   always @*
   begin
      hit_pll = {NUM_PLL{1'b0}};
      hit_tab = {NUM_SET{1'b0}};
      for (j = 0; j < NUM_PLL; j = j + 1)
      begin
         hit_pll[j] = (adr == `CPS_OFF_PLLCFG0 + `CPS_REG_STRIDE * j);
      end
      for (j = 0; j < NUM_SET; j = j + 1)
      begin
         hit_tab[j] = (adr == `CPS_OFF_TABLE0 + `CPS_REG_STRIDE * j);
      end
   end

   // ***********************************************
   // Pin role and index
   // ***********************************************

   // Committed role bit only; grounded supply forces serial
   assign serial_role = ~role_committed | output_supply_grounded;
   // Dual pins read as zero in serial role, pin a always control
   assign idx = serial_role ? {2'h0, ctrl_pin_a}
      : {ctrl_pin_c_dual, ctrl_pin_b_dual, ctrl_pin_a};
   assign ent = set_tab[idx];

   // ***********************************************
   // Per-PLL decode
   // ***********************************************
   genvar g;
   generate
      for (g = 0; g < NUM_PLL; g = g + 1)
      begin : pll_dec
         cps_pll_decode u_dec
         (
            .ent(ent[`CPS_ENT_PLL_BASE+g*`CPS_ENT_PLL_W+4:
               `CPS_ENT_PLL_BASE+g*`CPS_ENT_PLL_W]),
            .cfg(pll_cfg[g]),
            .freq_second(dec_freq[g]),
            .spread_code(dec_spread[3*g+2:3*g]),
            .spread_down(dec_down[g]),
            .out_state(dec_state[2*g+1:2*g])
         );
      end
   endgenerate

   // Primary output state from generic config
   assign next_gen_st = ent[`CPS_ENT_PRI] ? gen_cfg[`CPS_GEN_ST1_LO+1:`CPS_GEN_ST1_LO]
      : gen_cfg[`CPS_GEN_ST0_LO+1:`CPS_GEN_ST0_LO];

   // ***********************************************
   // Registered outputs
   // ***********************************************

   // Outputs follow selected setting one clock later
   always @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         serial_enable <= 1'b1;
         setting_index <= 3'h0;
         primary_output <= `CPS_ST_HIZ;
         pll_a_output_pair <= `CPS_ST_HIZ;
         pll_b_output_pair <= `CPS_ST_HIZ;
         pll_c_output_pair <= `CPS_ST_HIZ;
         pll_freq_select <= {NUM_PLL{1'b0}};
         pll_spread_code <= {3*NUM_PLL{1'b0}};
         pll_spread_down <= {NUM_PLL{1'b0}};
      end
      else
      begin
         serial_enable <= serial_role;
         setting_index <= idx;
         primary_output <= next_gen_st;
         pll_a_output_pair <= dec_state[1:0];
         pll_b_output_pair <= dec_state[3:2];
         pll_c_output_pair <= dec_state[5:4];
         pll_freq_select <= dec_freq;
         pll_spread_code <= dec_spread;
         pll_spread_down <= dec_down;
      end
   end

   // ***********************************************
   // Register writes
   // ***********************************************

   // Factory defaults on reset, byte lane 0 writes; table entries write byte lanes 0 and 1
   always @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         role_volatile <= `CPS_RST_ROLE;
         role_committed <= `CPS_RST_ROLE;
         commit_pend <= 1'b0;
         gen_cfg <= `CPS_RST_GENCFG;
         for (i = 0; i < NUM_PLL; i = i + 1)
         begin
            pll_cfg[i] <= `CPS_RST_PLLCFG;
         end
         set_tab[0] <= `CPS_RST_ENT0;
         set_tab[1] <= `CPS_RST_ENT1;
         for (i = 2; i < NUM_SET; i = i + 1)
         begin
            set_tab[i] <= `CPS_RST_ENTX;
         end
      end
      else
      begin
         commit_pend <= 1'b0;
         if (commit_pend)
         begin
            role_committed <= role_volatile;
         end
         if (wr_req && wb_sel_i[0])
         begin
            if (hit_pincfg)
            begin
               role_volatile <= wb_dat_i[`CPS_PINCFG_ROLE];
            end
            if (hit_commit)
            begin
               commit_pend <= wb_dat_i[`CPS_COMMIT_GO];
            end
            if (hit_gencfg)
            begin
               gen_cfg <= wb_dat_i[3:0];
            end
            for (i = 0; i < NUM_PLL; i = i + 1)
            begin
               if (hit_pll[i])
               begin
                  pll_cfg[i] <= wb_dat_i[4:0];
               end
            end
         end
         for (i = 0; i < NUM_SET; i = i + 1)
         begin
            if (wr_req && hit_tab[i])
            begin
               if (wb_sel_i[0])
               begin
                  set_tab[i][7:0] <= wb_dat_i[7:0];
               end
               if (wb_sel_i[1])
               begin
                  set_tab[i][15:8] <= wb_dat_i[15:8];
               end
            end
         end
      end
   end

   // ***********************************************
   // Register reads
   // ***********************************************

   // Read mux, unmapped reads zero
   always @*
   begin
      rd_data = `CPS_BAD_DATA;
      if (hit_pincfg)
      begin
         rd_data[`CPS_PINCFG_ROLE] = role_volatile;
      end
      if (hit_status)
      begin
         rd_data = {28'h0000000, serial_enable, setting_index};
      end
      if (hit_gencfg)
      begin
         rd_data = {28'h0000000, gen_cfg};
      end
      for (k = 0; k < NUM_PLL; k = k + 1)
      begin
         if (hit_pll[k])
         begin
            rd_data = {27'h0, pll_cfg[k]};
         end
      end
      for (k = 0; k < NUM_SET; k = k + 1)
      begin
         if (hit_tab[k])
         begin
            rd_data = {16'h0000, set_tab[k]};
         end
      end
   end

   // Single-wait ack, dropped the cycle after
   always @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end
      else
      begin
         wb_ack_o <= wr_req | rd_req;
         if (rd_req)
         begin
            wb_dat_o <= rd_data;
         end
      end
   end

endmodule

// File: src/cps_map.vh
/*
 Constants for the control pin setting select block: register offsets,
 field positions, reset values and codes.
 Assumes it is included by bare name from src/ design files.
*/
`ifndef CPS_MAP_VH
`define CPS_MAP_VH

// ***********************************************
// Register word offsets (byte addresses)
// ***********************************************
`define CPS_OFF_PINCFG 8'h00
`define CPS_OFF_COMMIT 8'h04
`define CPS_OFF_STATUS 8'h08
`define CPS_OFF_GENCFG 8'h0c
`define CPS_OFF_PLLCFG0 8'h10
`define CPS_OFF_TABLE0 8'h20
`define CPS_ADDR_W 8
`define CPS_REG_STRIDE 4

// ***********************************************
// Field positions
// ***********************************************
`define CPS_PINCFG_ROLE 6
`define CPS_COMMIT_GO 0
`define CPS_PLL_DOWN 0
`define CPS_PLL_ST0_LO 1
`define CPS_PLL_ST1_LO 3
`define CPS_GEN_ST0_LO 0
`define CPS_GEN_ST1_LO 2
// Table entry: [0] primary sel, then per PLL {out sel, spread[2:0], freq sel}
`define CPS_ENT_PRI 0
`define CPS_ENT_PLL_BASE 1
`define CPS_ENT_PLL_W 5
`define CPS_ENT_W 16

// ***********************************************
// Output state codes
// ***********************************************
`define CPS_ST_PDOWN 2'h0
`define CPS_ST_HIZ 2'h1
`define CPS_ST_LOW 2'h2
`define CPS_ST_ACTIVE 2'h3

// ***********************************************
// Factory defaults
// ***********************************************
`define CPS_RST_ROLE 1'h0
`define CPS_RST_GENCFG 4'hd
`define CPS_RST_PLLCFG 5'h1a
`define CPS_RST_ENT0 16'h0000
`define CPS_RST_ENT1 16'h8421
`define CPS_RST_ENTX 16'h0000
`define CPS_BAD_DATA 32'h0000_0000

`endif

// File: src/cps_pll_decode.v
/*
 Per-PLL decode of the selected control setting into frequency choice,
 spread amount, spread mode and output state.
 Assumes setting fields and configuration come from registered sources.
*/
`timescale 1ns/100ps
`include "cps_map.vh"

module cps_pll_decode
(
   input wire [4:0] ent,
   input wire [4:0] cfg,
   output reg freq_second,
   output reg [2:0] spread_code,
   output reg spread_down,
   output reg [1:0] out_state
);

   // ***********************************************
   // Field decode
   // ***********************************************

   // Split entry and pick configured state
   always @*
   begin
      freq_second = ent[0];
      spread_code = ent[3:1];
      spread_down = cfg[`CPS_PLL_DOWN];
      if (ent[4])
      begin
         out_state = cfg[`CPS_PLL_ST1_LO+1:`CPS_PLL_ST1_LO];
      end
      else
      begin
         out_state = cfg[`CPS_PLL_ST0_LO+1:`CPS_PLL_ST0_LO];
      end
   end

endmodule

// File: testbench/cps_select_monitor.sv
/*
 Checker: pin to setting relations, role changes, bus handshake.
 Assumes a bind to the cps_select ports, one clock domain.
*/
`timescale 1ns/100ps
module cps_select_monitor
(
   input wire core_clk,
   input wire rst_n,
   input wire ctrl_pin_a,
   input wire ctrl_pin_b_dual,
   input wire ctrl_pin_c_dual,
   input wire output_supply_grounded,
   input wire [31:0] wb_adr_i,
   input wire [31:0] wb_dat_i,
   input wire wb_we_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire [31:0] wb_dat_o,
   input wire wb_ack_o,
   input wire serial_enable,
   input wire [2:0] setting_index
);
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   // Commit write seen at its ack edge
   wire commit_wr = wb_ack_o && wb_we_i && wb_adr_i[7:0] == 8'h04 && wb_dat_i[0];
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_pulse;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   AST_ACK: assert property (s_req |=> s_pulse)
      else $error("ack not a pulse after request");
   AST_ACK_SRC: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   AST_UNMAP: assert property (wb_ack_o && !wb_we_i && wb_adr_i[7:0] >= 8'h40 |-> wb_dat_o == 0)
      else $error("unmapped read not zero");
   AST_IDX_HI: assert property (serial_enable && $past(serial_enable) |-> setting_index[2:1] == 0)
      else $error("serial role index high bits set");
   AST_IDX_A: assert property (serial_enable && $past(serial_enable) && $past(rst_n)
      |-> setting_index[0] == $past(ctrl_pin_a))
      else $error("index bit 0 not pin a");
   AST_IDX_FULL: assert property (!serial_enable && !$past(serial_enable)
      && !$past(output_supply_grounded)
      |-> setting_index == $past({ctrl_pin_c_dual, ctrl_pin_b_dual, ctrl_pin_a}))
      else $error("control role index wrong");
   AST_GND: assert property (output_supply_grounded |-> ##[1:2] serial_enable)
      else $error("grounded supply left control role");
   AST_ROLE: assert property ($fell(serial_enable) |-> $past(commit_wr, 2) || $past(commit_wr, 3)
      || $past(output_supply_grounded) || $past(output_supply_grounded, 2))
      else $error("role changed without commit");
endmodule

// File: testbench/cps_board.sv
/*
 Board model: control pin levels and serial bus traffic on shared pins.
 Assumes serial_enable tells which role the shared pins carry.
*/
`timescale 1ns/100ps
module cps_board
(
   input wire core_clk,
   input wire serial_enable,
   input wire [2:0] want,
   output wire ctrl_pin_a,
   output wire ctrl_pin_b_dual,
   output wire ctrl_pin_c_dual
);
   reg [1:0] bus_line = 2'h3;
   // Bus controller traffic, lines idle high outside the serial role
   always @(posedge core_clk)
   begin
      if (serial_enable === 1'b1)
         bus_line <= bus_line + 2'h1;
      else
         bus_line <= 2'h3;
   end
   // Pin levels as set by the board
   assign ctrl_pin_a = want[0];
   assign {ctrl_pin_c_dual, ctrl_pin_b_dual} = serial_enable ? bus_line : want[2:1];
endmodule

// File: testbench/cps_select_bench.sv
/*
 Bench for cps_select: factory settings, register access, roles.
 Assumes the board model drives the pins.
*/
`timescale 1ns/100ps
module cps_select_bench;
   reg core_clk, rst_n, gnd, req, we;
   reg [2:0] want;
   reg [31:0] adr, dat, r;
   reg [15:0] ent [0:7];
   reg [4:0] pcfg [0:2];
   reg [3:0] gen;
   integer i, g, fails, compares;
   wire [31:0] rdat;
   wire ack, ser, pa, pb, pc;
   wire [2:0] idx, fs, dn;
   wire [1:0] yp, ya, yb, yc;
   wire [8:0] sp;
   wire [22:0] outs = {yp, ya, yb, yc, fs, sp, dn};
   cps_board board (.core_clk(core_clk), .serial_enable(ser), .want(want),
      .ctrl_pin_a(pa), .ctrl_pin_b_dual(pb), .ctrl_pin_c_dual(pc));
   cps_select DUT (.core_clk(core_clk), .rst_n(rst_n), .ctrl_pin_a(pa), .ctrl_pin_b_dual(pb),
      .ctrl_pin_c_dual(pc), .output_supply_grounded(gnd), .wb_adr_i(adr), .wb_dat_i(dat),
      .wb_sel_i(4'hf), .wb_we_i(we), .wb_cyc_i(req), .wb_stb_i(req), .wb_dat_o(rdat),
      .wb_ack_o(ack), .serial_enable(ser), .setting_index(idx), .primary_output(yp),
      .pll_a_output_pair(ya), .pll_b_output_pair(yb), .pll_c_output_pair(yc),
      .pll_freq_select(fs), .pll_spread_code(sp), .pll_spread_down(dn));
   // Outputs expected for one setting
   function [22:0] expect_out(input [2:0] k);
      reg [15:0] e;
      reg [22:0] x;
      integer h;
      begin
         e = ent[k];
         x[22:21] = e[0] ? gen[3:2] : gen[1:0];
         for (h = 0; h < 3; h = h + 1)
         begin
            x[20-2*h -: 2] = e[5+5*h] ? pcfg[h][4:3] : pcfg[h][2:1];
            x[12+h] = e[1+5*h];
            x[3+3*h +: 3] = e[2+5*h +: 3];
            x[h] = pcfg[h][0];
         end
         expect_out = x;
      end
   endfunction
   task chk(input string n, input [31:0] seen, input [31:0] exp);
      begin
         compares = compares + 1;
         if (seen !== exp)
         begin
            fails = fails + 1;
            $display("wrong value %s expected %h seen %h", n, exp, seen);
         end
      end
   endtask
   // Model of the factory configuration
   task factory;
      begin
         for (g = 0; g < 8; g = g + 1) ent[g] = 16'h0;
         ent[1] = 16'h8421;
         gen = 4'hd;
         for (g = 0; g < 3; g = g + 1) pcfg[g] = 5'h1a;
      end
   endtask
   task close_out;
      begin
         $display("compares %0d fails %0d", compares, fails);
         if (fails == 0 && compares > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask
   task wb(input w, input [7:0] a, input [31:0] d);
      integer t;
      reg [31:0] hi;
      begin
         hi = $urandom;
         @(posedge core_clk);
         req <= 1'h1;
         we <= w;
         adr <= {hi[23:0], a};
         dat <= d;
         t = 0;
         do
         begin
            @(posedge core_clk);
            t = t + 1;
         end
         while (ack !== 1'h1 && t < 50);
         r = rdat;
         req <= 1'h0;
         chk("ack", ack, 1'h1);
      end
   endtask
   task rd(input [7:0] a, input [31:0] exp);
      begin
         wb(1'h0, a, 32'h0);
         chk("read", r, exp);
      end
   endtask
   task look(input [2:0] w, input s);
      reg [2:0] x;
      begin
         @(posedge core_clk);
         want <= w;
         repeat (2) @(posedge core_clk);
         @(negedge core_clk);
         x = s ? {2'h0, w[0]} : w;
         chk("role", ser, s);
         chk("index", idx, x);
         chk("outputs", outs, expect_out(x));
      end
   endtask
   initial
   begin
      core_clk = 1'h0;
      forever #25 core_clk = ~core_clk;
   end
   // Hang guard
   initial
   begin
      #1000000;
      fails = fails + 1;
      close_out;
   end
   // Main sequence
   initial
   begin
      {rst_n, gnd, req, we, want, adr, dat} = 0;
      fails = 0;
      compares = 0;
      void'($urandom(43));
      factory;
      repeat (5) @(posedge core_clk);
      rst_n <= 1'h1;
      for (i = 0; i < 8; i = i + 1) look($urandom, 1'h1);
      rd(8'h0c, gen);
      for (g = 0; g < 3; g = g + 1) rd(8'h10 + 4 * g, pcfg[g]);
      for (i = 0; i < 8; i = i + 1) rd(8'h20 + 4 * i, ent[i]);
      for (i = 0; i < 8; i = i + 1)
      begin
         ent[i] = $urandom;
         wb(1'h1, 8'h20 + 4 * i, ent[i]);
      end
      gen = $urandom;
      wb(1'h1, 8'h0c, gen);
      for (g = 0; g < 3; g = g + 1)
      begin
         pcfg[g] = $urandom;
         wb(1'h1, 8'h10 + 4 * g, pcfg[g]);
      end
      wb(1'h1, 8'h44, $urandom);
      rd(8'h44, 32'h0);
      for (i = 0; i < 6; i = i + 1) look($urandom, 1'h1);
      wb(1'h1, 8'h00, 32'h40);
      look(3'h7, 1'h1);
      rd(8'h00, 32'h40);
      rd(8'h08, 32'h9);
      wb(1'h1, 8'h04, 32'h1);
      for (i = 0; i < 24; i = i + 1) look(i < 8 ? i : $urandom, 1'h0);
      @(posedge core_clk);
      gnd <= 1'h1;
      look(3'h7, 1'h1);
      @(posedge core_clk);
      gnd <= 1'h0;
      look(3'h5, 1'h0);
      // Second reset brings back the factory configuration
      @(posedge core_clk);
      rst_n <= 1'h0;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'h1;
      factory;
      look(3'h6, 1'h1);
      look(3'h3, 1'h1);
      rd(8'h00, 32'h0);
      rd(8'h0c, gen);
      close_out;
   end
endmodule
bind cps_select cps_select_monitor u_mon (.core_clk(core_clk), .rst_n(rst_n),
   .ctrl_pin_a(ctrl_pin_a), .ctrl_pin_b_dual(ctrl_pin_b_dual),
   .ctrl_pin_c_dual(ctrl_pin_c_dual), .output_supply_grounded(output_supply_grounded),
   .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .serial_enable(serial_enable), .setting_index(setting_index));
